// ---- verilog/predriver_input_gating.v ----
// Input gating, phase status and serial port framing of a three phase predriver
//
// What this block does
// - Gate drives may be on only while both enables are high (AND).
// - A low high-side control input turns on that phase's high-side driver.
// - A high low-side control input turns on that phase's low-side driver.
// - Serial input is MSB first, sampled on the falling serial clock edge.
// - Serial output is high impedance while chip select is high.
// - Chip select low frames one command; port ignored otherwise.
// - Phase status is low while source is below half supply, else high.
// - Either enable low forces all drives off at once; other logic keeps going.
`timescale 1ns/10ps
`include "predriver_consts.vh"
module predriver_input_gating
  (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Enables
  input wire drive_enable_first,
  input wire drive_enable_second,
  // Phase control inputs
  input wire phase_a_high_side_in_n,
  input wire phase_b_high_side_in_n,
  input wire phase_c_high_side_in_n,
  input wire phase_a_low_side_in,
  input wire phase_b_low_side_in,
  input wire phase_c_low_side_in,
  // Gate drive commands, high means driver on
  output wire [2:0] high_gate_on,
  output wire [2:0] low_gate_on,
  // Phase comparator inputs, digitised levels
  input wire [`LEVEL_W-1:0] load_supply,
  input wire [`LEVEL_W-1:0] phase_a_high_fet_source,
  input wire [`LEVEL_W-1:0] phase_b_high_fet_source,
  input wire [`LEVEL_W-1:0] phase_c_high_fet_source,
  // Phase status outputs
  output reg phase_a_level_status,
  output reg phase_b_level_status,
  output reg phase_c_level_status,
  // Serial port
  input wire serial_clk,
  input wire chip_select_n,
  input wire serial_in,
  output reg serial_out,
  output reg serial_out_oe_n,
  // Received command word
  output reg [`FRAME_BITS-1:0] rx_word,
  output reg rx_valid,
  input wire [`FRAME_BITS-1:0] tx_word
  );

  // ------------------------------------------------------------
  // Synchronisers
  // ------------------------------------------------------------
  wire enable_first_s;
  wire enable_second_s;
  wire [2:0] hs_n_s;
  wire [2:0] ls_s;
  wire sclk_s;
  wire cs_n_s;
  wire si_s;
  wire [8:0] pins_raw;
  wire [8:0] pins_s;
  assign pins_raw = {drive_enable_first, drive_enable_second, phase_c_high_side_in_n,
                     phase_b_high_side_in_n, phase_a_high_side_in_n, phase_c_low_side_in,
                     phase_b_low_side_in, phase_a_low_side_in, serial_in};
  genvar gi;
  generate
    for (gi = 0; gi < 9; gi = gi + 1)
    begin : g_sync
      // Active low inputs rest high, so a reset never shows a driver request
      pin_sync #(.RESET_VAL((gi >= 4 && gi <= 6) ? 1'b1 : 1'b0)) u_sync
        (
        .mclk(mclk),
        .rst_n(rst_n),
        .pin(pins_raw[gi]),
        .level(pins_s[gi])
        );
    end
  endgenerate
  assign {enable_first_s, enable_second_s, hs_n_s, ls_s, si_s} = pins_s;
  pin_sync #(.RESET_VAL(1'b1)) u_cs
    (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin(chip_select_n),
    .level(cs_n_s)
    );
  pin_sync #(.RESET_VAL(1'b0)) u_sclk
    (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin(serial_clk),
    .level(sclk_s)
    );

  // ------------------------------------------------------------
  // Gate drive gating
  // ------------------------------------------------------------
  reg [2:0] hs_req_r;
  reg [2:0] ls_req_r;
  wire enable_raw;
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hs_req_r <= 3'h0;
      ls_req_r <= 3'h0;
    end
    else
    begin
      hs_req_r <= ~hs_n_s & {3{enable_first_s & enable_second_s}};
      ls_req_r <= ls_s & {3{enable_first_s & enable_second_s}};
    end
  end
  // Raw pins kill the drive without waiting for the synchroniser delay
  assign enable_raw = drive_enable_first & drive_enable_second;
  assign high_gate_on = hs_req_r & {3{enable_raw}};
  assign low_gate_on = ls_req_r & {3{enable_raw}};

  // ------------------------------------------------------------
  // Phase comparators
  // ------------------------------------------------------------
  function below_half;
    input [`LEVEL_W-1:0] src;
    input [`LEVEL_W-1:0] sup;
    begin
      // Compare 2*src with sup to avoid losing the low bit of sup/2
      below_half = ({1'b0, src} * `HALF_SUPPLY_DEN) < ({1'b0, sup} * `HALF_SUPPLY_NUM);
    end
  endfunction
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase_a_level_status <= 1'b0;
      phase_b_level_status <= 1'b0;
      phase_c_level_status <= 1'b0;
    end
    else
    begin
      phase_a_level_status <= ~below_half(phase_a_high_fet_source, load_supply);
      phase_b_level_status <= ~below_half(phase_b_high_fet_source, load_supply);
      phase_c_level_status <= ~below_half(phase_c_high_fet_source, load_supply);
    end
  end

  // ------------------------------------------------------------
  // Serial port
  // ------------------------------------------------------------
  reg sclk_d_r;
  reg [`FRAME_BITS-1:0] rx_sh_r;
  reg [`FRAME_BITS-1:0] tx_sh_r;
  reg [`BIT_CNT_W-1:0] bit_cnt_r;
  reg cs_d_r;
  wire fall;
  wire rise;
  wire frame_start;
  wire frame_end;
  assign fall = sclk_d_r & ~sclk_s;
  assign rise = ~sclk_d_r & sclk_s;
  assign frame_start = cs_d_r & ~cs_n_s;
  assign frame_end = ~cs_d_r & cs_n_s;
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
      rx_sh_r <= `RX_RESET;
      tx_sh_r <= `TX_RESET;
      bit_cnt_r <= 4'h0;
      rx_word <= `RX_RESET;
      rx_valid <= 1'b0;
      serial_out <= `SO_IDLE;
      serial_out_oe_n <= 1'b1;
    end
    else
    begin
      sclk_d_r <= sclk_s;
      cs_d_r <= cs_n_s;
      rx_valid <= 1'b0;
      serial_out_oe_n <= cs_n_s;
      if (cs_n_s)
      begin
        // Outside a frame the port ignores clock and data
        bit_cnt_r <= 4'h0;
        serial_out <= `SO_IDLE;
      end
      else if (frame_start)
      begin
        tx_sh_r <= tx_word;
        serial_out <= tx_word[`FRAME_BITS-1];
        bit_cnt_r <= 4'h0;
      end
      else
      begin
        if (fall)
        begin
          rx_sh_r <= {rx_sh_r[`FRAME_BITS-2:0], si_s};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end
        if (rise && bit_cnt_r != 4'h0)
        begin
          tx_sh_r <= {tx_sh_r[`FRAME_BITS-2:0], 1'b0};
          serial_out <= tx_sh_r[`FRAME_BITS-2];
        end
      end
      // A frame counts only if its falling-edge count, wrapping at 16, ends at eight
      if (frame_end && bit_cnt_r == `FULL_FRAME_CNT)
      begin
        rx_word <= rx_sh_r;
        rx_valid <= 1'b1;
      end
    end
  end
endmodule // predriver_input_gating

// ---- verilog/predriver_consts.vh ----
// Constants for the predriver input gating block
`ifndef PREDRIVER_CONSTS_VH
`define PREDRIVER_CONSTS_VH
`define FRAME_BITS 8
`define BIT_CNT_W 4
`define FULL_FRAME_CNT 4'h8
`define SYNC_DEPTH 3
`define SO_IDLE 1'b0
`define HALF_SUPPLY_NUM 1
`define HALF_SUPPLY_DEN 2
`define LEVEL_W 12
`define RX_RESET 8'h00
`define TX_RESET 8'h00
`endif

// ---- verilog/pin_sync.v ----
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module pin_sync
  #(parameter RESET_VAL = 1'b0)
  (
  // Clock and reset
  input wire mclk,
  input wire rst_n,
  // Pin and filtered level
  input wire pin,
  output reg level
  );
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= RESET_VAL;
      s2_r <= RESET_VAL;
      s3_r <= RESET_VAL;
      level <= RESET_VAL;
    end
    else
    begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      // Change counts only once second and third stages agree
      if (s2_r == s3_r)
        level <= s3_r;
    end
  end
endmodule // pin_sync

// ---- dv/host_model.sv ----
// Host side serial driver for the predriver bench
`timescale 1ns/10ps
module host_model(output reg serial_clk, output reg chip_select_n, output reg serial_in,
  input serial_out, input serial_out_oe_n, output reg [7:0] so_byte);
  initial {serial_clk, chip_select_n, serial_in, so_byte} = 11'h200;
  // Clock idles low; 125 ns period
  task frame(input [7:0] d, input integer n);
    integer k;
    begin
      chip_select_n = 1'b0;
      so_byte = 8'h00;
      #500;
      for (k = 7; k > 7 - n; k = k - 1)
      begin
        #62.5 serial_clk = 1'b1;
        serial_in = d[k];
        #62.5 serial_clk = 1'b0;
        // Reply taken on the falling edge; an undriven line reads inverted
        so_byte = {so_byte[6:0], serial_out_oe_n ? ~serial_out : serial_out};
      end
      #500 chip_select_n = 1'b1;
      // Released line has no pull, so show the opposite level
      serial_in = ~serial_in;
    end
  endtask
  // Clock and data wiggle while deselected, which the port must ignore
  task stray(input integer n);
    begin
      repeat (n)
      begin
        #62.5 serial_clk = 1'b1;
        serial_in = ~serial_in;
        #62.5 serial_clk = 1'b0;
      end
    end
  endtask
endmodule // host_model

// ---- dv/predriver_input_gating_properties.sv ----
// Port assertions for the predriver gating block
`timescale 1ns/10ps
module predriver_input_gating_properties(
  input mclk, rst_n, drive_enable_first, drive_enable_second, chip_select_n,
  input phase_a_high_side_in_n, phase_a_low_side_in, phase_a_level_status,
  input [11:0] load_supply, phase_a_high_fet_source,
  input [2:0] high_gate_on, low_gate_on,
  input serial_out_oe_n, rx_valid, input [7:0] rx_word);
  wire en = drive_enable_first & drive_enable_second;
  wire [12:0] a2 = {phase_a_high_fet_source, 1'b0};
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_GATE_AND: assert property (!en |-> {high_gate_on, low_gate_on} == 6'h00)
    else $error("gate on without enables");
  AST_HS_ON: assert property ((!phase_a_high_side_in_n && en)[*8] |-> high_gate_on[0])
    else $error("high side not on");
  AST_LS_ON: assert property ((phase_a_low_side_in && en)[*8] |-> low_gate_on[0])
    else $error("low side not on");
  AST_SYNC_DELAY: assert property ($rose(phase_a_low_side_in) && !low_gate_on[0] |=> !low_gate_on[0])
    else $error("unsynchronised gate");
  AST_STATUS: assert property (1 |=> phase_a_level_status == ($past(a2) >= {1'b0, $past(load_supply)}))
    else $error("status wrong");
  AST_SO_HIZ: assert property (chip_select_n[*8] |-> serial_out_oe_n)
    else $error("output driven while deselected");
  AST_SO_START: assert property ($fell(serial_out_oe_n) |-> !chip_select_n)
    else $error("output driven early");
  AST_RX_PULSE: assert property (rx_valid |-> chip_select_n ##1 !rx_valid)
    else $error("bad word strobe");
  AST_RX_HOLD: assert property ($changed(rx_word) |-> rx_valid)
    else $error("word changed unannounced");
  cover property (rx_valid);
  cover property (high_gate_on[0]);
  cover property (!serial_out_oe_n);
endmodule // predriver_input_gating_properties
bind predriver_input_gating predriver_input_gating_properties u_props (
  .mclk(mclk), .rst_n(rst_n), .drive_enable_first(drive_enable_first),
  .drive_enable_second(drive_enable_second), .chip_select_n(chip_select_n),
  .phase_a_high_side_in_n(phase_a_high_side_in_n), .phase_a_low_side_in(phase_a_low_side_in),
  .phase_a_level_status(phase_a_level_status), .load_supply(load_supply),
  .phase_a_high_fet_source(phase_a_high_fet_source), .high_gate_on(high_gate_on),
  .low_gate_on(low_gate_on), .serial_out_oe_n(serial_out_oe_n), .rx_valid(rx_valid),
  .rx_word(rx_word));

// ---- dv/tb_predriver_input_gating.sv ----
// Self-checking bench for the predriver gating block
`timescale 1ns/10ps
module tb_predriver_input_gating;
  reg mclk = 0, rst_n = 0, ena = 0, enb = 0;
  reg [2:0] hs_n = 3'h7, ls = 3'h0;
  reg [11:0] sup = 0, sa = 0, sb = 0, sc = 0;
  reg [7:0] tx = 0, d = 0, last = 0;
  wire [2:0] hg, lg;
  wire [7:0] rxw;
  wire sta, stb, stc, so, so_oe_n, rxv, sclk, csn, si;
  wire [7:0] so_byte;
  reg [15:0] n_valid = 16'h0;
  integer bad_count = 0, n_compared = 0, i;
  host_model u_host_model(.serial_clk(sclk), .chip_select_n(csn), .serial_in(si),
    .serial_out(so), .serial_out_oe_n(so_oe_n), .so_byte(so_byte));
  predriver_input_gating u_predriver_input_gating(.mclk(mclk), .rst_n(rst_n),
    .drive_enable_first(ena), .drive_enable_second(enb),
    .phase_a_high_side_in_n(hs_n[0]), .phase_b_high_side_in_n(hs_n[1]), .phase_c_high_side_in_n(hs_n[2]),
    .phase_a_low_side_in(ls[0]), .phase_b_low_side_in(ls[1]), .phase_c_low_side_in(ls[2]),
    .high_gate_on(hg), .low_gate_on(lg), .load_supply(sup), .phase_a_high_fet_source(sa),
    .phase_b_high_fet_source(sb), .phase_c_high_fet_source(sc), .phase_a_level_status(sta),
    .phase_b_level_status(stb), .phase_c_level_status(stc), .serial_clk(sclk), .chip_select_n(csn),
    .serial_in(si), .serial_out(so), .serial_out_oe_n(so_oe_n), .rx_word(rxw), .rx_valid(rxv), .tx_word(tx));
  initial forever #5 mclk = ~mclk;
  // Word strobes are counted where they are settled
  always @(negedge mclk)
    if (rxv === 1'b1)
      n_valid <= n_valid + 16'h1;
  function [5:0] gates(input e1, e2, input [2:0] h_n, l);
    gates = (e1 & e2) ? {~h_n, l} : 6'h00;
  endfunction
  function st(input [11:0] s, p);
    st = {s, 1'b0} >= {1'b0, p};
  endfunction
  task chk(input [15:0] got, exp);
    begin
      n_compared = n_compared + 1;
      if (got !== exp)
      begin
        bad_count = bad_count + 1;
        $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task final_report;
    begin
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    #100000 bad_count = bad_count + 1;
    final_report;
  end
  initial
  begin
    i = $urandom(15);
    repeat (6) @(posedge mclk);
    @(negedge mclk) rst_n = 1;
    repeat (6) @(posedge mclk);
    for (i = 0; i < 40; i = i + 1)
    begin
      @(negedge mclk) {ena, enb, hs_n, ls} = (i < 2) ? 8'hC7 : 8'($urandom);
      {sup, sa, sb, sc} = 48'({$urandom, $urandom});
      // Exactly half supply counts as not below
      if (i == 0) {sup, sa, sb} = {12'h800, 12'h400, 12'h3FF};
      repeat (8) @(posedge mclk);
      #1 chk({hg, lg}, gates(ena, enb, hs_n, ls));
      chk({sta, stb, stc}, {st(sa, sup), st(sb, sup), st(sc, sup)});
    end
    // All drives on, then one enable drops: gates must die before the synchroniser sees it
    @(negedge mclk) {ena, enb, hs_n, ls} = 8'hC7;
    repeat (8) @(posedge mclk);
    #1 chk({hg, lg}, gates(ena, enb, hs_n, ls));
    @(negedge mclk) enb = 0;
    #1 chk({hg, lg}, 6'h00);
    for (i = 0; i < 4; i = i + 1)
    begin
      @(negedge mclk) d = (i == 0) ? 8'h81 : 8'($urandom);
      tx = ~d;
      chk(so_oe_n, 1'b1);
      #1 fork
        u_host_model.frame(d, (i == 3) ? 7 : 8);
        begin
          repeat (20) @(posedge mclk);
          #1 chk({so_oe_n, so}, {1'b0, tx[7]});
        end
      join
      if (i < 3) chk(so_byte, tx);
      repeat (10) @(posedge mclk);
      #1 chk(rxw, (i == 3) ? last : d);
      chk(n_valid, 16'((i < 3) ? i + 1 : 3));
      if (i < 3)
        last = d;
    end
    u_host_model.stray(8);
    repeat (10) @(posedge mclk);
    #1 chk({so_oe_n, rxw}, {1'b1, last});
    chk(n_valid, 16'h3);
    final_report;
  end
endmodule // tb_predriver_input_gating
